// ==== bench/tb.sv ====
// self-checking bench for abd_core: apb driver, table of operations, reset and refusals
// assumes the slave answers every access after one wait state and drives no interrupt
module tb
   import abd_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {
      logic [7:0] acc0, f0;
      logic [2:0] flg0, op;
      logic       dest;
      logic [2:0] b;
      logic [6:0] fa;
      logic [7:0] lit, e_acc, e_file;
      logic [2:0] e_flg;
   } abd_row_t;
   logic        core_clk = 1'b0;
   logic        rstn     = 1'b0;
   logic        psel     = 1'b0;
   logic        penable  = 1'b0;
   logic        pwrite   = 1'b0;
   logic [11:0] paddr    = 12'h000;
   logic [31:0] pwdata   = 32'h0000_0000;
   logic        pready, pslverr, op_done_o;
   logic [31:0] prdata, rd;
   logic [7:0]  acc_o;
   abd_flags_t  flags_o;
   logic        er;
   int          errors   = 0;
   int          n_tests  = 0;
   // flags column order is {null, nibble, overflow}, as the status register holds it
   abd_row_t rows [11] = '{
      '{8'h8f,8'h00,3'h0,ABD_OP_ADDLIT,1'b0,3'h0,7'h00,8'h71,8'h00,8'h00,3'h7},
      '{8'h00,8'h00,3'h7,ABD_OP_ADDLIT,1'b0,3'h0,7'h00,8'hff,8'hff,8'h00,3'h0},
      '{8'h18,8'h28,3'h0,ABD_OP_ADDFILE,1'b0,3'h0,7'h7f,8'h00,8'h40,8'h28,3'h2},
      '{8'hf0,8'h20,3'h6,ABD_OP_ADDFILE,1'b1,3'h0,7'h00,8'h00,8'hf0,8'h10,3'h1},
      '{8'haa,8'h00,3'h3,ABD_OP_ANDLIT,1'b0,3'h0,7'h00,8'h55,8'h00,8'h00,3'h7},
      '{8'h3c,8'hf0,3'h7,ABD_OP_ANDFILE,1'b1,3'h0,7'h05,8'h00,8'h3c,8'h30,3'h3},
      '{8'h0f,8'hf0,3'h0,ABD_OP_ANDFILE,1'b0,3'h0,7'h40,8'h00,8'h00,8'hf0,3'h4},
      '{8'h55,8'hff,3'h5,ABD_OP_BITCLR,1'b0,3'h7,7'h7f,8'h00,8'h55,8'h7f,3'h5},
      '{8'h55,8'h01,3'h2,ABD_OP_BITCLR,1'b1,3'h0,7'h03,8'h00,8'h55,8'h00,3'h2},
      '{8'h55,8'h00,3'h3,ABD_OP_BITSET,1'b0,3'h7,7'h01,8'h00,8'h55,8'h80,3'h3},
      '{8'h55,8'hfe,3'h4,ABD_OP_BITSET,1'b0,3'h0,7'h02,8'h00,8'h55,8'hff,3'h4}};

   abd_core i_abd_core (.core_clk(core_clk), .rstn(rstn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .acc_o(acc_o), .flags_o(flags_o), .op_done_o(op_done_o));

   always #4 core_clk = ~core_clk;

   function automatic logic [11:0] fadr(input logic [6:0] fa);
      return ABD_FILE_BASE | {3'h0, fa, 2'b00};
   endfunction : fadr

   task automatic close_out();
      $display("comparisons %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : close_out

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
      n_tests++;
      if (exp !== seen) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   // request held from setup until pready is sampled high at a rising edge
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      int n;
      @(posedge core_clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge core_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) chk("pready", 32'h1, 32'h0);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic cmd(input abd_row_t r);
      apb(1'b1, ABD_CMD_OFS, {8'h00, r.lit, 1'b0, r.fa, 1'b0, r.b, r.dest, r.op});
      #1;
   endtask : cmd

   task automatic reset_state(input string name);
      #1;
      chk({name, " acc"}, 32'h0, {24'h0, acc_o});
      chk({name, " flags"}, 32'h0, {29'h0, flags_o});
      apb(1'b0, fadr(7'h7f), 32'h0);
      chk({name, " file"}, 32'h0, rd);
      $display("test %s done", name);
   endtask : reset_state

   initial begin
      repeat (6000) @(posedge core_clk);
      errors++;
      $display("watchdog expired");
      close_out();
   end

   initial begin
      abd_row_t r;
      repeat (8) @(posedge core_clk);
      rstn <= 1'b1;
      reset_state("reset");
      foreach (rows[i]) begin
         r = rows[i];
         apb(1'b1, ABD_ACC_OFS, {24'h0, r.acc0});
         apb(1'b1, fadr(r.fa), {24'h0, r.f0});
         apb(1'b1, ABD_STAT_OFS, {29'h0, r.flg0});
         cmd(r);
         chk("cmd err", 32'h0, {31'h0, er});
         chk("op_done", 32'h1, {31'h0, op_done_o});
         chk("acc_o", {24'h0, r.e_acc}, {24'h0, acc_o});
         chk("flags_o", {29'h0, r.e_flg}, {29'h0, flags_o});
         apb(1'b0, fadr(r.fa), 32'h0);
         chk("file", {24'h0, r.e_file}, rd);
         apb(1'b0, ABD_STAT_OFS, 32'h0);
         chk("status", {29'h0, r.e_flg}, rd);
         $display("test row %0d done", i);
      end
      // back-to-back literal adds: nibble carry appears then clears
      r = rows[0];
      r.lit = 8'h01;
      apb(1'b1, ABD_ACC_OFS, 32'h0000_000f);
      cmd(r);
      chk("chain acc", 32'h10, {24'h0, acc_o});
      chk("chain flags", 32'h2, {29'h0, flags_o});
      cmd(r);
      chk("chain acc", 32'h11, {24'h0, acc_o});
      chk("chain flags", 32'h0, {29'h0, flags_o});
      $display("test chain done");
      // op codes 0 and 7 are refused and leave the accumulator alone
      foreach (rows[i]) if (i < 2) begin
         r.op = (i == 0) ? 3'h0 : 3'h7;
         cmd(r);
         chk("refused err", 32'h1, {31'h0, er});
         chk("refused done", 32'h0, {31'h0, op_done_o});
         chk("refused acc", 32'h11, {24'h0, acc_o});
      end
      apb(1'b0, 12'h00c, 32'h0);
      chk("unmapped data", 32'h0, rd);
      chk("unmapped err", 32'h1, {31'h0, er});
      $display("test refusals done");
      apb(1'b1, fadr(7'h7f), 32'h0000_00a5);
      @(posedge core_clk);
      rstn <= 1'b0;
      repeat (2) @(posedge core_clk);
      rstn <= 1'b1;
      reset_state("second reset");
      close_out();
   end
endmodule : tb

// ==== verilog/abd_core.sv ====
// add / and / bit-op datapath with accumulator, file registers and flags
// assumes an apb master on core_clk; one command per command-word write
module abd_core
   import abd_pkg::*;
(
   // clock and reset
   input  wire logic              core_clk,
   input  wire logic              rstn,
   // apb slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ABD_AW-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   output logic                   pready,
   output logic [31:0]            prdata,
   output logic                   pslverr,
   // datapath state
   output logic [7:0]             acc_o,
   output abd_flags_t             flags_o,
   output logic                   op_done_o
);
   logic [7:0]  acc_r;
   logic [7:0]  acc_nxt;
   abd_flags_t  flags_r;
   abd_flags_t  flags_nxt;
   logic [7:0]  file_r   [ABD_FILE_DEPTH];
   logic [7:0]  file_nxt [ABD_FILE_DEPTH];
   logic        pready_r;
   logic        pready_nxt;
   logic [31:0] prdata_r;
   logic [31:0] prdata_nxt;
   logic        pslverr_r;
   logic        pslverr_nxt;
   logic        done_r;
   logic        done_nxt;

   abd_cmd_t    cmd;
   logic        acc_phase;
   logic        xfer_done;
   logic        hit_cmd;
   logic        hit_acc;
   logic        hit_stat;
   logic        hit_file;
   logic [6:0]  fidx;
   logic        op_legal;
   logic        ex;
   logic [7:0]  fsel;
   logic [7:0]  opnd;
   logic [8:0]  sum9;
   logic [4:0]  low5;
   logic [7:0]  res;
   logic        bad;

   assign cmd.op      = pwdata[ABD_OP_MSB:ABD_OP_LSB];
   assign cmd.dest    = pwdata[ABD_DEST_BIT];
   assign cmd.bitpos  = pwdata[ABD_BIT_MSB:ABD_BIT_LSB];
   assign cmd.faddr   = pwdata[ABD_FADDR_MSB:ABD_FADDR_LSB];
   assign cmd.lit     = pwdata[ABD_LIT_MSB:ABD_LIT_LSB];

   // one wait state: pready rises in the second access cycle
   assign acc_phase = psel & penable;
   assign xfer_done = acc_phase & pready_r;
   assign hit_cmd   = (paddr == ABD_CMD_OFS);
   assign hit_acc   = (paddr == ABD_ACC_OFS);
   assign hit_stat  = (paddr == ABD_STAT_OFS);
   assign hit_file  = (paddr[ABD_FSEL_MSB:ABD_FSEL_LSB] == ABD_FILE_BASE[ABD_FSEL_MSB:ABD_FSEL_LSB]);
   assign fidx      = paddr[ABD_FIDX_MSB:ABD_FIDX_LSB];
   assign op_legal  = (cmd.op != ABD_OP_NONE) && (cmd.op <= ABD_OP_BITSET);
   assign ex        = xfer_done & pwrite & hit_cmd & op_legal;
   assign fsel      = file_r[cmd.faddr];
   assign bad       = !(hit_cmd | hit_acc | hit_stat | hit_file) | (pwrite & hit_cmd & !op_legal);

   // shared adder for both add forms
   always_comb begin
      opnd = ((cmd.op == ABD_OP_ADDFILE) || (cmd.op == ABD_OP_ANDFILE)) ? fsel : cmd.lit;
      sum9 = {1'b0, acc_r} + {1'b0, opnd};
      low5 = {1'b0, acc_r[3:0]} + {1'b0, opnd[3:0]};
      res  = ((cmd.op == ABD_OP_ANDLIT) || (cmd.op == ABD_OP_ANDFILE)) ? (acc_r & opnd) : sum9[7:0];
   end

   // apb answer
   always_comb begin
      pready_nxt  = acc_phase & !pready_r;
      prdata_nxt  = ABD_RD_ZERO;
      pslverr_nxt = 1'b0;
      if (pready_nxt) begin
         pslverr_nxt = bad;
         if (!pwrite) begin
            if (hit_acc) begin
               prdata_nxt = {24'h00_0000, acc_r};
            end else if (hit_stat) begin
               prdata_nxt = {29'h0000_0000, flags_r};
            end else if (hit_file) begin
               prdata_nxt = {24'h00_0000, file_r[fidx]};
            end
         end
      end
   end

   // datapath next state
   always_comb begin
      acc_nxt   = acc_r;
      flags_nxt = flags_r;
      file_nxt  = file_r;
      done_nxt  = ex;
      if (xfer_done && pwrite && !bad) begin
         if (hit_acc) begin
            acc_nxt = pwdata[7:0];
         end else if (hit_stat) begin
            flags_nxt.ovf    = pwdata[ABD_OVF_BIT];
            flags_nxt.nib    = pwdata[ABD_NIB_BIT];
            flags_nxt.null_f = pwdata[ABD_NULL_BIT];
         end else if (hit_file) begin
            file_nxt[fidx] = pwdata[7:0];
         end
      end
      if (ex) begin
         case (cmd.op)
            ABD_OP_ADDLIT: begin
               acc_nxt          = res;
               flags_nxt.ovf    = sum9[8];
               flags_nxt.nib    = low5[4];
               flags_nxt.null_f = (res == 8'h00);
            end
            ABD_OP_ADDFILE, ABD_OP_ANDFILE: begin
               if (cmd.dest == ABD_DEST_FILE) begin
                  file_nxt[cmd.faddr] = res;
               end else begin
                  acc_nxt = res;
               end
               flags_nxt.null_f = (res == 8'h00);
               if (cmd.op == ABD_OP_ADDFILE) begin
                  flags_nxt.ovf = sum9[8];
                  flags_nxt.nib = low5[4];
               end
            end
            ABD_OP_ANDLIT: begin
               acc_nxt          = res;
               flags_nxt.null_f = (res == 8'h00);
            end
            ABD_OP_BITCLR: begin
               file_nxt[cmd.faddr][cmd.bitpos] = 1'b0;
            end
            ABD_OP_BITSET: begin
               file_nxt[cmd.faddr][cmd.bitpos] = 1'b1;
            end
            default: begin
               acc_nxt = acc_r;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         acc_r     <= ABD_ACC_RST;
         flags_r   <= ABD_FLAGS_RST;
         file_r    <= '{default: ABD_FILE_RST};
         pready_r  <= 1'b0;
         prdata_r  <= ABD_RD_ZERO;
         pslverr_r <= 1'b0;
         done_r    <= 1'b0;
      end else begin
         acc_r     <= acc_nxt;
         flags_r   <= flags_nxt;
         file_r    <= file_nxt;
         pready_r  <= pready_nxt;
         prdata_r  <= prdata_nxt;
         pslverr_r <= pslverr_nxt;
         done_r    <= done_nxt;
      end
   end

   assign pready    = pready_r;
   assign prdata    = prdata_r;
   assign pslverr   = pslverr_r;
   assign acc_o     = acc_r;
   assign flags_o   = flags_r;
   assign op_done_o = done_r;

   // checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);

   logic [7:0] chk_acc_r;
   logic [7:0] chk_opnd_r;
   logic [8:0] chk_sum;
   logic [4:0] chk_low;

   // adder inputs of the previous cycle, so the checks rebuild the sum apart from the datapath
   always_ff @(posedge core_clk) begin
      chk_acc_r  <= acc_r;
      chk_opnd_r <= opnd;
   end

   assign chk_sum = {1'b0, chk_acc_r} + {1'b0, chk_opnd_r};
   assign chk_low = {1'b0, chk_acc_r[3:0]} + {1'b0, chk_opnd_r[3:0]};

   // datapath results, and the one wait state of pready

   property p_add_lit;
      ex && cmd.op == ABD_OP_ADDLIT |=> acc_r == chk_sum[7:0] && flags_r.ovf == chk_sum[8];
   endproperty
   a_add_lit: assert property (p_add_lit) else $error("add literal result wrong");

   property p_add_file;
      ex && cmd.op == ABD_OP_ADDFILE |=> flags_r.nib == chk_low[4] && flags_r.ovf == chk_sum[8];
   endproperty
   a_add_file: assert property (p_add_file) else $error("add file flags wrong");

   property p_dest_file;
      ex && cmd.op == ABD_OP_ADDFILE && cmd.dest == ABD_DEST_FILE
         |=> $stable(acc_r) && file_r[$past(cmd.faddr)] == chk_sum[7:0];
   endproperty
   a_dest_file: assert property (p_dest_file) else $error("file destination wrong");

   property p_and_file;
      ex && cmd.op == ABD_OP_ANDFILE |=> $stable(flags_r.ovf) && $stable(flags_r.nib);
   endproperty
   a_and_file: assert property (p_and_file) else $error("and file touched carries");

   property p_and_lit;
      ex && cmd.op == ABD_OP_ANDLIT
         |=> acc_r == ($past(acc_r) & $past(opnd)) && $stable(flags_r.ovf);
   endproperty
   a_and_lit: assert property (p_and_lit) else $error("and literal wrong");

   property p_bit_clr;
      ex && cmd.op == ABD_OP_BITCLR
         |=> !file_r[$past(cmd.faddr)][$past(cmd.bitpos)] && $stable(flags_r) && $stable(acc_r);
   endproperty
   a_bit_clr: assert property (p_bit_clr) else $error("bit clear wrong");

   property p_bit_set;
      ex && cmd.op == ABD_OP_BITSET
         |=> file_r[$past(cmd.faddr)][$past(cmd.bitpos)] && $stable(flags_r);
   endproperty
   a_bit_set: assert property (p_bit_set) else $error("bit set wrong");

   property p_null;
      ex && cmd.op != ABD_OP_BITCLR && cmd.op != ABD_OP_BITSET
         |=> flags_r.null_f == ($past(res) == 8'h00);
   endproperty
   a_null: assert property (p_null) else $error("zero flag wrong");

   property p_ready;
      psel && penable && !pready |=> pready ##1 !pready;
   endproperty
   a_ready: assert property (p_ready) else $error("pready not one wait state");

   property p_add_acc;
      ex && cmd.op == ABD_OP_ADDFILE && cmd.dest == ABD_DEST_ACC
         |=> acc_r == chk_sum[7:0] && file_r[$past(cmd.faddr)] == $past(fsel);
   endproperty
   a_add_acc: assert property (p_add_acc) else $error("add to accumulator wrong");

   property p_and_acc;
      ex && cmd.op == ABD_OP_ANDFILE && cmd.dest == ABD_DEST_ACC
         |=> acc_r == ($past(acc_r) & $past(fsel)) && flags_r.null_f == (acc_r == 8'h00);
   endproperty
   a_and_acc: assert property (p_and_acc) else $error("and file value wrong");

   // only the addressed bit may move; the mask hides it on both sides
   property p_clr_keep;
      ex && cmd.op == ABD_OP_BITCLR
         |=> (file_r[$past(cmd.faddr)] | (8'h01 << $past(cmd.bitpos)))
             == ($past(fsel) | (8'h01 << $past(cmd.bitpos)));
   endproperty
   a_clr_keep: assert property (p_clr_keep) else $error("bit clear touched other bits");

   property p_set_keep;
      ex && cmd.op == ABD_OP_BITSET
         |=> (file_r[$past(cmd.faddr)] & ~(8'h01 << $past(cmd.bitpos)))
             == ($past(fsel) & ~(8'h01 << $past(cmd.bitpos))) && $stable(acc_r);
   endproperty
   a_set_keep: assert property (p_set_keep) else $error("bit set touched other bits");

   // bus side and bookkeeping
   property p_done;
      ex |=> op_done_o;
   endproperty
   a_done: assert property (p_done) else $error("op done pulse missing");

   property p_refuse;
      xfer_done && pwrite && bad |=> $stable(acc_r) && $stable(flags_r) && !op_done_o;
   endproperty
   a_refuse: assert property (p_refuse) else $error("refused write had an effect");

   // answer lines rest at zero so a stale read cannot leak
   property p_rd_idle;
      !pready |-> prdata == ABD_RD_ZERO && !pslverr;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside answer cycle");

   property p_acc_wr;
      xfer_done && pwrite && hit_acc |=> acc_r == $past(pwdata[7:0]);
   endproperty
   a_acc_wr: assert property (p_acc_wr) else $error("accumulator write lost");

   property p_stat_wr;
      xfer_done && pwrite && hit_stat
         |=> {flags_r.null_f, flags_r.nib, flags_r.ovf} == $past(pwdata[ABD_NULL_BIT:ABD_OVF_BIT]);
   endproperty
   a_stat_wr: assert property (p_stat_wr) else $error("status write lost");

   property p_file_wr;
      xfer_done && pwrite && hit_file |=> file_r[$past(fidx)] == $past(pwdata[7:0]);
   endproperty
   a_file_wr: assert property (p_file_wr) else $error("file register write lost");

   c_and_null:  cover property (ex && cmd.op == ABD_OP_ANDLIT ##1 flags_r.null_f);

   c_add_carry: cover property (ex && cmd.op == ABD_OP_ADDLIT ##1 flags_r.ovf);
   c_file_dest: cover property (ex && cmd.op == ABD_OP_ANDFILE && cmd.dest == ABD_DEST_FILE);
   c_bit_set:   cover property (ex && cmd.op == ABD_OP_BITSET);
   c_err:       cover property (pslverr);
endmodule : abd_core

// ==== verilog/abd_pkg.sv ====
// constants and carrier types for the add and bit-op datapath
// assumes a single core clock and an apb master on the same clock
// Notes on behaviour
// - add literal to accumulator, set all flags
// - add file and accumulator, result to accumulator or file register, set all flags
// - destination zero accumulator, one file register
// - and with file updates zero flag only
// - and literal into accumulator, zero flag only
// - bit clear touches one bit, no flags
// - bit set touches one bit, no flags
package abd_pkg;
   // apb map, byte addresses
   localparam int          ABD_AW        = 12;
   localparam logic [11:0] ABD_CMD_OFS   = 12'h000;
   localparam logic [11:0] ABD_ACC_OFS   = 12'h004;
   localparam logic [11:0] ABD_STAT_OFS  = 12'h008;
   localparam logic [11:0] ABD_FILE_BASE = 12'h200;
   localparam int          ABD_FSEL_MSB  = 11;
   localparam int          ABD_FSEL_LSB  = 9;
   localparam int          ABD_FIDX_MSB  = 8;
   localparam int          ABD_FIDX_LSB  = 2;
   localparam int          ABD_FILE_DEPTH = 128;
   // command word fields
   localparam int ABD_OP_LSB    = 0;
   localparam int ABD_OP_MSB    = 2;
   localparam int ABD_DEST_BIT  = 3;
   localparam int ABD_BIT_LSB   = 4;
   localparam int ABD_BIT_MSB   = 6;
   localparam int ABD_FADDR_LSB = 8;
   localparam int ABD_FADDR_MSB = 14;
   localparam int ABD_LIT_LSB   = 16;
   localparam int ABD_LIT_MSB   = 23;
   // status register bits
   localparam int ABD_OVF_BIT  = 0;
   localparam int ABD_NIB_BIT  = 1;
   localparam int ABD_NULL_BIT = 2;
   // operation codes
   localparam logic [2:0] ABD_OP_NONE    = 3'h0;
   localparam logic [2:0] ABD_OP_ADDLIT  = 3'h1;
   localparam logic [2:0] ABD_OP_ADDFILE = 3'h2;
   localparam logic [2:0] ABD_OP_ANDLIT  = 3'h3;
   localparam logic [2:0] ABD_OP_ANDFILE = 3'h4;
   localparam logic [2:0] ABD_OP_BITCLR  = 3'h5;
   localparam logic [2:0] ABD_OP_BITSET  = 3'h6;
   // destination selector
   localparam logic ABD_DEST_ACC  = 1'b0;
   localparam logic ABD_DEST_FILE = 1'b1;
   // reset values
   localparam logic [7:0]  ABD_ACC_RST  = 8'h00;
   localparam logic [7:0]  ABD_FILE_RST = 8'h00;
   localparam logic [31:0] ABD_RD_ZERO  = 32'h0000_0000;

   typedef struct packed {
      logic null_f;
      logic nib;
      logic ovf;
   } abd_flags_t;

   typedef struct packed {
      logic [7:0] lit;
      logic [6:0] faddr;
      logic [2:0] bitpos;
      logic       dest;
      logic [2:0] op;
   } abd_cmd_t;

   localparam abd_flags_t ABD_FLAGS_RST = '{null_f: 1'b0, nib: 1'b0, ovf: 1'b0};
endpackage : abd_pkg
